// ### design/wss_top.sv
// Segment selector with table loader and AHB-Lite registers
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
// Contract
// - Active segment is 1..32000, reset value 1.
// - Trace operations use the active segment until another is chosen.
// - Sync output tracks the selected segment.
// - Active segment read returns selected index.
// - Remote source (default): only commands change segment.
// - External source: 8 data lines plus valid select up to 256.
// - Source readback reports remote or external.
// - Timing mode applies equally to remote and external requests.
// - Coherent: new segment starts after current waveform end point.
// - Immediate (default): abort and start new segment at once.
// - Timing readback reports coherent or immediate.
// - Table block: hash, digit count, byte count multiple of four.
// - Each entry is a 32-bit length in four bytes.
// - Segments numbered from one, each placed after the previous.
// - Each channel keeps own table; load hits selected channel.
// - Loading a table replaces all existing segments.
// - Table holds 1 to 32000 segments; code stores at most TBL_DEPTH per channel, further entries set the error.
// - Basic memory: segment at most 32M points.
// - Table load leaves waveform memory untouched.
// - Any byte value accepted in payload.
// - Length at least 384 and multiple of 32, else error.
module wss_top #(
  parameter int NUM_CHAN = 2,
  parameter int TBL_DEPTH = 8
)
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic [7:0] EXT_SEL_I,
  input wire logic EXT_VALID_I,
  input wire logic WAVE_END_I,
  output logic [wss_pkg::SEG_W-1:0] PLAY_SEG_O,
  output logic SEG_SWITCH_O,
  output logic SYNC_SEG_O,
  output logic [wss_pkg::LEN_W-1:0] PLAY_START_O
);
  import wss_pkg::*;

  localparam int CH_W = (NUM_CHAN > 1) ? $clog2(NUM_CHAN) : 1;
  localparam int IX_W = $clog2(TBL_DEPTH);

  logic src_ext_ff;
  logic coh_ff;
  logic [CH_W-1:0] chan_ff;
  logic [SEG_W-1:0] active_ff;
  logic [SEG_W-1:0] pend_seg_ff;
  logic pend_ff;
  logic err_ff;
  logic [31:0] tbl_len_ff [NUM_CHAN][TBL_DEPTH];
  logic [31:0] tbl_start_ff [NUM_CHAN][TBL_DEPTH];
  logic [SEG_W-1:0] seg_cnt_ff [NUM_CHAN];
  logic [31:0] next_start_ff;
  logic [SEG_W-1:0] lookup_ff;
  wss_load_type ld_state_ff;
  logic [3:0] ndig_ff;
  logic [31:0] bcount_ff;
  logic [31:0] bleft_ff;
  logic [1:0] bpos_ff;
  logic [31:0] word_ff;
  logic [SEG_W-1:0] wr_idx_ff;
  logic ap_wr_ff;
  logic [7:0] ap_addr_ff;
  logic sync_ff;

  logic ap_valid;
  logic req_valid;
  logic [SEG_W-1:0] req_seg;
  logic byte_valid;
  logic [7:0] byte_val;
  logic [31:0] full_word;
  logic [IX_W-1:0] look_ix;

  function automatic logic seg_ok(input logic [SEG_W-1:0] s);
    seg_ok = (s != '0) && (s <= SEG_MAX);
  endfunction : seg_ok

  function automatic logic len_ok(input logic [31:0] l);
    len_ok = (l >= LEN_MIN) && (l <= LEN_MAX) && ((l & LEN_GRAIN_MASK) == 32'h0000_0000);
  endfunction : len_ok

  assign ap_valid = HSEL_I && HREADY_I && HTRANS_I[1];
  assign byte_valid = ap_wr_ff && (ap_addr_ff == ADDR_TBL);
  assign byte_val = HWDATA_I[7:0];
  assign full_word = {byte_val, word_ff[31:8]};
  assign look_ix = lookup_ff[IX_W-1:0] - IX_W'(1);

  // Request source and gating
  always_comb
  begin
    req_valid = 1'b0;
    req_seg = active_ff;
    if (src_ext_ff)
    begin
      req_valid = EXT_VALID_I;
      req_seg = SEG_W'(EXT_SEL_I) + SEG_W'(1);
    end
    else if (ap_wr_ff && (ap_addr_ff == ADDR_SEL) && seg_ok(HWDATA_I[SEG_W-1:0]))
    begin
      req_valid = 1'b1;
      req_seg = HWDATA_I[SEG_W-1:0];
    end
  end

  // Address phase capture
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      ap_wr_ff <= 1'b0;
      ap_addr_ff <= 8'h00;
    end
    else
    begin
      ap_wr_ff <= ap_valid && HWRITE_I;
      ap_addr_ff <= ap_valid ? HADDR_I[7:0] : ap_addr_ff;
    end
  end

  // Control register
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      src_ext_ff <= 1'b0;
      coh_ff <= 1'b0;
      chan_ff <= '0;
      lookup_ff <= SEG_DEFAULT;
    end
    else if (ap_wr_ff && (ap_addr_ff == ADDR_CTRL))
    begin
      src_ext_ff <= HWDATA_I[CTRL_SRC_BIT];
      coh_ff <= HWDATA_I[CTRL_COH_BIT];
      chan_ff <= HWDATA_I[CTRL_CHAN_BIT +: CH_W];
    end
    else if (ap_wr_ff && (ap_addr_ff == ADDR_LOOKUP))
    begin
      lookup_ff <= HWDATA_I[SEG_W-1:0];
    end
  end

  // Active segment and transition timing
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      active_ff <= SEG_DEFAULT;
      pend_seg_ff <= SEG_DEFAULT;
      pend_ff <= 1'b0;
      SEG_SWITCH_O <= 1'b0;
      PLAY_SEG_O <= SEG_DEFAULT;
    end
    else
    begin
      SEG_SWITCH_O <= 1'b0;
      if (req_valid && !coh_ff)
      begin
        active_ff <= req_seg;
        PLAY_SEG_O <= req_seg;
        pend_ff <= 1'b0;
        SEG_SWITCH_O <= 1'b1;
      end
      else if (req_valid)
      begin
        active_ff <= req_seg;
        pend_seg_ff <= req_seg;
        pend_ff <= 1'b1;
      end
      else if (pend_ff && WAVE_END_I)
      begin
        PLAY_SEG_O <= pend_seg_ff;
        pend_ff <= 1'b0;
        SEG_SWITCH_O <= 1'b1;
      end
    end
  end

  // Sync follows the selected segment
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      sync_ff <= 1'b0;
      SYNC_SEG_O <= 1'b0;
      PLAY_START_O <= 32'h0000_0000;
    end
    else
    begin
      sync_ff <= SEG_SWITCH_O;
      SYNC_SEG_O <= sync_ff && (PLAY_SEG_O == active_ff);
      PLAY_START_O <= tbl_start_ff[chan_ff][PLAY_SEG_O[IX_W-1:0] - IX_W'(1)];
    end
  end

  // Table block parser
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      ld_state_ff <= LD_IDLE;
      ndig_ff <= 4'h0;
      bcount_ff <= 32'h0000_0000;
      bleft_ff <= 32'h0000_0000;
      bpos_ff <= 2'b00;
      word_ff <= 32'h0000_0000;
    end
    else if (byte_valid)
    begin
      unique case (ld_state_ff)
        LD_IDLE:
        begin
          if (byte_val == HASH_CHAR)
          begin
            ld_state_ff <= LD_NDIG;
          end
        end
        LD_NDIG:
        begin
          ndig_ff <= 4'(byte_val - DIGIT_ZERO);
          bcount_ff <= 32'h0000_0000;
          ld_state_ff <= LD_COUNT;
        end
        LD_COUNT:
        begin
          bcount_ff <= 32'(bcount_ff * 32'd10) + 32'(byte_val - DIGIT_ZERO);
          ndig_ff <= ndig_ff - 4'h1;
          bpos_ff <= 2'b00;
          if (ndig_ff == 4'h1)
          begin
            bleft_ff <= 32'(bcount_ff * 32'd10) + 32'(byte_val - DIGIT_ZERO);
            ld_state_ff <= LD_DATA;
          end
        end
        LD_DATA:
        begin
          word_ff <= full_word;
          bpos_ff <= bpos_ff + 2'b01;
          bleft_ff <= bleft_ff - 32'h0000_0001;
          if (bleft_ff == 32'h0000_0001)
          begin
            ld_state_ff <= LD_IDLE;
          end
        end
      endcase
    end
  end

  // Segment table storage per channel
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      err_ff <= 1'b0;
      wr_idx_ff <= '0;
      next_start_ff <= 32'h0000_0000;
      for (int c = 0; c < NUM_CHAN; c++)
      begin
        seg_cnt_ff[c] <= '0;
        for (int i = 0; i < TBL_DEPTH; i++)
        begin
          tbl_len_ff[c][i] <= 32'h0000_0000;
          tbl_start_ff[c][i] <= 32'h0000_0000;
        end
      end
    end
    else
    begin
      if (ap_wr_ff && (ap_addr_ff == ADDR_STAT) && HWDATA_I[STAT_ERR_BIT])
      begin
        err_ff <= 1'b0;
      end
      if ((ap_wr_ff && (ap_addr_ff == ADDR_CTRL) && HWDATA_I[CTRL_CLR_BIT]) ||
          (byte_valid && (ld_state_ff == LD_COUNT) && (ndig_ff == 4'h1)))
      begin
        seg_cnt_ff[chan_ff] <= '0;
        wr_idx_ff <= '0;
        next_start_ff <= 32'h0000_0000;
        if (byte_valid && ((32'(bcount_ff * 32'd10) + 32'(byte_val - DIGIT_ZERO)) &
            CNT_MULT_MASK) != 32'h0000_0000)
        begin
          err_ff <= 1'b1;
        end
      end
      else if (byte_valid && (ld_state_ff == LD_DATA) && (bpos_ff == 2'b11))
      begin
        if (!len_ok(full_word) || (wr_idx_ff >= SEG_MAX) ||
            (32'(wr_idx_ff) >= TBL_DEPTH))
        begin
          err_ff <= 1'b1;
        end
        else
        begin
          tbl_len_ff[chan_ff][wr_idx_ff[IX_W-1:0]] <= full_word;
          tbl_start_ff[chan_ff][wr_idx_ff[IX_W-1:0]] <= next_start_ff;
          next_start_ff <= next_start_ff + full_word;
          wr_idx_ff <= wr_idx_ff + SEG_W'(1);
          seg_cnt_ff[chan_ff] <= wr_idx_ff + SEG_W'(1);
        end
      end
    end
  end

  // Bus read data
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      HRDATA_O <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
    else
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      HRDATA_O <= 32'h0000_0000;
      if (ap_valid && !HWRITE_I)
      begin
        unique case (HADDR_I[7:0])
          ADDR_CTRL: HRDATA_O <= {28'h0, 1'(chan_ff), 1'b0, coh_ff, src_ext_ff};
          ADDR_SEL, ADDR_ACTIVE: HRDATA_O <= 32'(active_ff);
          ADDR_STAT: HRDATA_O <= {1'b0, seg_cnt_ff[chan_ff], 15'h0, err_ff};
          ADDR_LOOKUP: HRDATA_O <= 32'(lookup_ff);
          ADDR_START: HRDATA_O <= tbl_start_ff[chan_ff][look_ix];
          ADDR_LEN: HRDATA_O <= tbl_len_ff[chan_ff][look_ix];
          default: HRDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  property p_reset_seg;
    @(posedge CORE_CLK_I) $fell(RST_I) |-> active_ff == SEG_DEFAULT;
  endproperty
  a_reset_seg: assert property (p_reset_seg) else $error("active not default");

  property p_imm;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      req_valid && !coh_ff |=> PLAY_SEG_O == $past(req_seg) && SEG_SWITCH_O;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate switch missed");

  property p_coh_hold;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      req_valid && coh_ff && !pend_ff |=> !SEG_SWITCH_O;
  endproperty
  a_coh_hold: assert property (p_coh_hold) else $error("coherent switched early");

  property p_coh_end;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      pend_ff && WAVE_END_I && !req_valid |=> SEG_SWITCH_O && PLAY_SEG_O == active_ff;
  endproperty
  a_coh_end: assert property (p_coh_end) else $error("coherent end not taken");

  property p_remote_only;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      !src_ext_ff && !(ap_wr_ff && ap_addr_ff == ADDR_SEL) |=> $stable(active_ff);
  endproperty
  a_remote_only: assert property (p_remote_only) else $error("segment changed w/o cmd");

  property p_ext_sample;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      src_ext_ff && EXT_VALID_I |=> active_ff == SEG_W'($past(EXT_SEL_I)) + SEG_W'(1);
  endproperty
  a_ext_sample: assert property (p_ext_sample) else $error("ext select not taken");

  property p_range;
    @(posedge CORE_CLK_I) disable iff (RST_I) seg_ok(active_ff);
  endproperty
  a_range: assert property (p_range) else $error("active out of range");
  property p_sync;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      SEG_SWITCH_O && !req_valid ##1 !req_valid |=> SYNC_SEG_O;
  endproperty
  a_sync: assert property (p_sync) else $error("sync not raised");
  property p_ready;
    @(posedge CORE_CLK_I) disable iff (RST_I) HREADYOUT_O && !HRESP_O;
  endproperty
  a_ready: assert property (p_ready) else $error("bus not ready");
  c_imm: cover property (@(posedge CORE_CLK_I) req_valid && !coh_ff);
  c_coh: cover property (@(posedge CORE_CLK_I) pend_ff && WAVE_END_I);
  c_ext: cover property (@(posedge CORE_CLK_I) src_ext_ff && EXT_VALID_I);
  c_load: cover property (@(posedge CORE_CLK_I) ld_state_ff == LD_DATA && bleft_ff == 32'h1);
endmodule : wss_top

// ### dv/tb_top.sv
// Self-checking bench for the waveform segment selector
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) \
    begin \
      fails++; \
      $display("[ERR] %s exp %0h got %0h", nm, ex, got); \
    end \
  end
module tb_top;
  import wss_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hsel = 1'b0;
  logic [2:0] hsize = 3'b000;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [7:0] ext_sel;
  logic ext_valid;
  logic wave_end;
  logic [SEG_W-1:0] play_seg;
  logic seg_sw;
  logic sync_seg;
  logic [LEN_W-1:0] play_start;
  logic [31:0] rd;
  int fails = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  wss_top #(.NUM_CHAN(2), .TBL_DEPTH(8)) DUT
  (
    .CORE_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .EXT_SEL_I(ext_sel),
    .EXT_VALID_I(ext_valid), .WAVE_END_I(wave_end), .PLAY_SEG_O(play_seg),
    .SEG_SWITCH_O(seg_sw), .SYNC_SEG_O(sync_seg), .PLAY_START_O(play_start)
  );
  wss_ext_src u_src (.clk_i(clk), .sel_o(ext_sel), .valid_o(ext_valid), .end_o(wave_end));
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hsize <= 3'b010;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : bus
  task automatic tbl_hdr(input int nbytes);
    bus(1'b1, ADDR_TBL, {24'h0, HASH_CHAR});
    if (nbytes > 9)
    begin
      bus(1'b1, ADDR_TBL, {24'h0, DIGIT_ZERO + 8'h02});
      bus(1'b1, ADDR_TBL, {24'h0, DIGIT_ZERO + 8'(nbytes / 10)});
    end
    else
      bus(1'b1, ADDR_TBL, {24'h0, DIGIT_ZERO + 8'h01});
    bus(1'b1, ADDR_TBL, {24'h0, DIGIT_ZERO + 8'(nbytes % 10)});
  endtask : tbl_hdr
  task automatic tbl_len(input logic [31:0] len);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, ADDR_TBL, {24'h0, len[8*i +: 8]});
    end
  endtask : tbl_len
  task automatic t_reset();
    bus(1'b0, ADDR_CTRL, 32'h0);
    `CHK("ctrl", 2'h0, rd[1:0])
    bus(1'b0, ADDR_ACTIVE, 32'h0);
    `CHK("active", 32'h1, rd)
    `CHK("play", 15'h0001, play_seg)
    bus(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, rd)
  endtask : t_reset
  task automatic t_remote();
    u_src.pick(8'h07);
    repeat (2) @(posedge clk);
    #1;
    `CHK("play", 15'h0001, play_seg)
    bus(1'b1, ADDR_SEL, 32'h4);
    #1;
    `CHK("play", 15'h0004, play_seg)
    `CHK("switch", 1'b1, seg_sw)
    repeat (2) @(posedge clk);
    #1;
    `CHK("sync", 1'b1, sync_seg)
    bus(1'b1, ADDR_SEL, 32'h0);
    bus(1'b1, ADDR_SEL, 32'h7D01);
    bus(1'b0, ADDR_SEL, 32'h0);
    `CHK("active", 32'h4, rd)
    bus(1'b1, ADDR_SEL, 32'h7D00);
    bus(1'b0, ADDR_ACTIVE, 32'h0);
    `CHK("active", 32'h7D00, rd)
  endtask : t_remote
  task automatic t_ext();
    bus(1'b1, ADDR_CTRL, 32'h1);
    bus(1'b0, ADDR_CTRL, 32'h0);
    `CHK("src", 1'b1, rd[0])
    u_src.pick(8'hFF);
    repeat (2) @(posedge clk);
    #1;
    `CHK("play", 15'h0100, play_seg)
    bus(1'b1, ADDR_SEL, 32'h5);
    bus(1'b0, ADDR_ACTIVE, 32'h0);
    `CHK("active", 32'h100, rd)
  endtask : t_ext
  task automatic t_coherent();
    bus(1'b1, ADDR_CTRL, 32'h3);
    bus(1'b0, ADDR_CTRL, 32'h0);
    `CHK("timing", 2'h3, rd[1:0])
    u_src.pick(8'h09);
    repeat (4) @(posedge clk);
    #1;
    `CHK("play", 15'h0100, play_seg)
    u_src.wave_end();
    @(posedge clk);
    #1;
    `CHK("play", 15'h000A, play_seg)
    bus(1'b1, ADDR_CTRL, 32'h2);
    bus(1'b1, ADDR_SEL, 32'h7);
    repeat (3) @(posedge clk);
    #1;
    `CHK("play", 15'h000A, play_seg)
    u_src.wave_end();
    @(posedge clk);
    #1;
    `CHK("play", 15'h0007, play_seg)
    bus(1'b1, ADDR_CTRL, 32'h0);
  endtask : t_coherent
  task automatic t_table();
    tbl_hdr(12);
    tbl_len(32'd640);
    tbl_len(32'd992 + 32'd32);
    tbl_len(32'd2016 + 32'd32);
    bus(1'b0, ADDR_STAT, 32'h0);
    `CHK("count", 15'h0003, rd[30:16])
    `CHK("err", 1'b0, rd[0])
    bus(1'b1, ADDR_LOOKUP, 32'h2);
    bus(1'b0, ADDR_START, 32'h0);
    `CHK("start", 32'd640, rd)
    bus(1'b0, ADDR_LEN, 32'h0);
    `CHK("len", 32'd1024, rd)
    bus(1'b1, ADDR_SEL, 32'h3);
    @(posedge clk);
    #1;
    `CHK("pstart", 32'd1664, play_start)
    bus(1'b1, ADDR_CTRL, 32'h8);
    bus(1'b0, ADDR_STAT, 32'h0);
    `CHK("count", 15'h0000, rd[30:16])
    tbl_hdr(4);
    tbl_len(32'd400);
    bus(1'b0, ADDR_STAT, 32'h0);
    `CHK("err", 1'b1, rd[0])
    bus(1'b1, ADDR_STAT, 32'h1);
    bus(1'b0, ADDR_STAT, 32'h0);
    `CHK("err", 1'b0, rd[0])
    tbl_hdr(4);
    tbl_len(32'h0200_0020);
    bus(1'b0, ADDR_STAT, 32'h0);
    `CHK("err", 1'b1, rd[0])
    bus(1'b1, ADDR_STAT, 32'h1);
    tbl_hdr(5);
    tbl_len(32'd384);
    bus(1'b1, ADDR_TBL, 32'h0);
    bus(1'b0, ADDR_STAT, 32'h0);
    `CHK("err", 1'b1, rd[0])
    bus(1'b1, ADDR_STAT, 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h0);
    bus(1'b0, ADDR_STAT, 32'h0);
    `CHK("count", 15'h0003, rd[30:16])
    tbl_hdr(4);
    tbl_len(32'd384);
    bus(1'b0, ADDR_STAT, 32'h0);
    `CHK("count", 15'h0001, rd[30:16])
    bus(1'b1, ADDR_LOOKUP, 32'h1);
    bus(1'b0, ADDR_START, 32'h0);
    `CHK("start", 32'h0, rd)
    bus(1'b1, ADDR_CTRL, 32'h4);
    bus(1'b0, ADDR_STAT, 32'h0);
    `CHK("count", 15'h0000, rd[30:16])
  endtask : t_table
  task automatic stop_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    #100000;
    fails++;
    stop_test();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_remote();
    t_ext();
    t_coherent();
    t_table();
    stop_test();
  end
endmodule : tb_top

// ### dv/wss_ext_src.sv
// External segment-select source and player end-point model
`timescale 1ns/100ps
module wss_ext_src
(
  input wire logic clk_i,
  output logic [7:0] sel_o,
  output logic valid_o,
  output logic end_o
);
  initial
  begin
    sel_o = 8'hA5;
    valid_o = 1'b0;
    end_o = 1'b0;
  end
  // One qualified code; lines inverted once released
  task automatic pick(input logic [7:0] code);
    sel_o <= code;
    valid_o <= 1'b1;
    @(posedge clk_i);
    valid_o <= 1'b0;
    sel_o <= ~code;
  endtask : pick
  // Final point of the playing waveform
  task automatic wave_end();
    end_o <= 1'b1;
    @(posedge clk_i);
    end_o <= 1'b0;
  endtask : wave_end
endmodule : wss_ext_src

// ### pkg/wss_pkg.sv
// Package for the waveform segment selector: map, fields, limits
package wss_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SEL = 8'h04;
  localparam logic [7:0] ADDR_ACTIVE = 8'h08;
  localparam logic [7:0] ADDR_TBL = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_LOOKUP = 8'h14;
  localparam logic [7:0] ADDR_START = 8'h18;
  localparam logic [7:0] ADDR_LEN = 8'h1C;
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_COH_BIT = 1;
  localparam int CTRL_CLR_BIT = 2;
  localparam int CTRL_CHAN_BIT = 3;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_CNT_LSB = 16;
  localparam int SEG_W = 15;
  localparam int LEN_W = 32;
  localparam logic [14:0] SEG_DEFAULT = 15'h0001;
  localparam logic [14:0] SEG_MAX = 15'h7D00;
  localparam logic [31:0] LEN_MIN = 32'h0000_0180;
  localparam logic [31:0] LEN_MAX = 32'h0200_0000;
  localparam logic [31:0] LEN_GRAIN_MASK = 32'h0000_001F;
  localparam logic [31:0] CNT_MULT_MASK = 32'h0000_0003;
  localparam logic [7:0] HASH_CHAR = 8'h23;
  localparam logic [7:0] DIGIT_ZERO = 8'h30;
  typedef enum logic [1:0]
  {
    LD_IDLE = 2'b00,
    LD_NDIG = 2'b01,
    LD_COUNT = 2'b10,
    LD_DATA = 2'b11
  } wss_load_type;
endpackage : wss_pkg
